/* File: inc/port_ctrl_pkg.sv */
// Constants, register map and carrier types of the port-control block.
// Assumes a byte-wide processor access port with bit and byte writes.
package port_ctrl_pkg;

    localparam int NPORT = 8;
    localparam int NASEL = 3;

    // Port numbers behind the eight port slots
    localparam logic [19:0] PORT_NUM [NPORT] = '{
        20'h00000, 20'h00001, 20'h00002, 20'h00003,
        20'h00004, 20'h00005, 20'h0000C, 20'h0000E};
    localparam int P0_IX = 0;
    localparam int P2_IX = 2;
    localparam int P3_IX = 3;
    localparam int P4_IX = 4;
    localparam int P5_IX = 5;
    localparam int P12_IX = 6;
    localparam int P14_IX = 7;

    localparam logic [19:0] LATCH_BASE = 20'hFFF00;
    localparam logic [19:0] DIR_BASE = 20'hFFF20;
    localparam logic [19:0] PULLUP_BASE = 20'hF0030;
    localparam logic [19:0] TTL_BASE = 20'hF0040;
    localparam logic [19:0] ODRAIN_BASE = 20'hF0050;
    localparam logic [19:0] ASEL_ADDR [NASEL] = '{
        20'hF0060, 20'hF006C, 20'hF006E};
    localparam logic [19:0] GROUP_CFG_ADDR = 20'hF0076;
    localparam logic [19:0] REDIRECT_ADDR = 20'hF0079;

    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'hFF;
    localparam logic [7:0] PULLUP_RST = 8'h00;
    localparam logic [7:0] PULLUP4_RST = 8'h01;
    localparam logic [7:0] TTL_RST = 8'h00;
    localparam logic [7:0] ODRAIN_RST = 8'h00;
    localparam logic [7:0] ASEL_RST = 8'hFF;
    localparam logic [3:0] GROUP_CFG_RST = 4'h0;
    localparam logic [3:0] REDIRECT_RST = 4'h0;

    localparam logic [3:0] GROUP_ALL_ANALOG = 4'h0;
    localparam logic [3:0] GROUP_ALL_DIGITAL = 4'h1;
    localparam logic [3:0] GROUP_MAX = 4'h8;

    // Redirect field codes
    localparam logic [1:0] OUT_TO_P30 = 2'b00;
    localparam logic [1:0] OUT_TO_P50 = 2'b01;
    localparam logic [1:0] OUT_TO_P00 = 2'b10;
    localparam logic [1:0] IO_TO_P01 = 2'b00;
    localparam logic [1:0] IO_TO_P31 = 2'b01;
    localparam logic [1:0] IO_TO_PORT4_BIT1 = 2'b10;

    typedef struct packed {
        logic rd;
        logic wr;
        logic bit_op;
        logic [2:0] bit_idx;
        logic bit_val;
        logic [19:0] addr;
        logic [7:0] wdata;
    } cpu_req_s;

endpackage : port_ctrl_pkg

/* File: logic/port_analog_select_redirect_io.sv */
// Port latches, direction, pull-up, buffer and analog selection with
// timer pin redirection. The processor side issues at most one access
// per cycle; pins are sampled synchronously to clk.
`timescale 1ns/1ps

module port_analog_select_redirect_io
    import port_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire cpu_req_s cpu,
    output logic [7:0] cpu_rdata,
    input wire logic [NPORT-1:0][7:0] pin_in,
    output logic [NPORT-1:0][7:0] pin_out,
    output logic [NPORT-1:0][7:0] pin_oe_n,
    output logic [NPORT-1:0][7:0] pullup_on,
    output logic [NPORT-1:0][7:0] ttl_on,
    output logic [7:0] group_analog,
    output logic [3:0] dual_analog,
    input wire logic timer_out_signal,
    input wire logic timer_io_signal,
    output logic timer_io_in
);

    logic [7:0] latch_ff [NPORT];
    logic [7:0] dir_ff [NPORT];
    logic [7:0] pullup_ff [NPORT];
    logic [7:0] ttl_ff [NPORT];
    logic [7:0] odrain_ff [NPORT];
    logic [7:0] asel_ff [NASEL];
    logic [3:0] group_cfg_ff;
    logic [3:0] redirect_ff;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic [7:0] analog [NPORT];
    logic [7:0] rd_val [NPORT];
    logic [7:0] alt_en [NPORT];
    logic [NPORT-1:0] lat_sel;
    logic [NPORT-1:0] dir_sel;
    logic [NPORT-1:0] pu_sel;
    logic [NPORT-1:0] ttl_sel;
    logic [NPORT-1:0] od_sel;
    logic [NASEL-1:0] asel_sel;

    // Byte write, or bit write merged into the given operand
    function automatic logic [7:0] merge(input logic [7:0] operand,
                                         input cpu_req_s req);
        logic [7:0] res;
        res = operand;
        if (req.bit_op) begin
            res[req.bit_idx] = req.bit_val;
        end else begin
            res = req.wdata;
        end
        return res;
    endfunction : merge

    function automatic logic [7:0] group_decode(input logic [3:0] cfg);
        logic [8:0] ones;
        ones = (9'h001 << (cfg - 4'h1)) - 9'h001;
        if (cfg == GROUP_ALL_ANALOG) begin
            return 8'hFF;
        end else if (cfg > GROUP_MAX || cfg == GROUP_ALL_DIGITAL) begin
            return 8'h00;
        end else begin
            return ones[7:0];
        end
    endfunction : group_decode

    // Address decode
    always_comb begin
        for (int i = 0; i < NPORT; i++) begin
            lat_sel[i] = cpu.wr && cpu.addr == LATCH_BASE + PORT_NUM[i];
            dir_sel[i] = cpu.wr && cpu.addr == DIR_BASE + PORT_NUM[i];
            pu_sel[i] = cpu.wr && cpu.addr == PULLUP_BASE + PORT_NUM[i];
            ttl_sel[i] = cpu.wr && cpu.addr == TTL_BASE + PORT_NUM[i];
            od_sel[i] = cpu.wr && cpu.addr == ODRAIN_BASE + PORT_NUM[i];
        end
        for (int j = 0; j < NASEL; j++) begin
            asel_sel[j] = cpu.wr && cpu.addr == ASEL_ADDR[j];
        end
    end

    // Analog pins: four dual-use pins and the converter group
    always_comb begin
        group_analog = group_decode(group_cfg_ff);
        dual_analog = {asel_ff[2][7], asel_ff[1][0],
                       asel_ff[0][1], asel_ff[0][0]};
        for (int i = 0; i < NPORT; i++) begin
            analog[i] = 8'h00;
        end
        analog[P0_IX][1:0] = asel_ff[0][1:0];
        analog[P12_IX][0] = asel_ff[1][0];
        analog[P14_IX][7] = asel_ff[2][7];
        analog[P2_IX] = group_analog;
    end

    // Per-bit read value; analog pins read as zero
    always_comb begin
        for (int i = 0; i < NPORT; i++) begin
            rd_val[i] = ((dir_ff[i] & pin_in[i])
                       | (~dir_ff[i] & latch_ff[i]))
                       & ~analog[i];
        end
    end

    // Output latches; bit writes are read-modify-write on the read value
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NPORT; i++) begin
                latch_ff[i] <= LATCH_RST;
            end
        end else begin
            for (int i = 0; i < NPORT; i++) begin
                if (lat_sel[i]) begin
                    latch_ff[i] <= merge(rd_val[i], cpu);
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NPORT; i++) begin
                dir_ff[i] <= DIR_RST;
            end
        end else begin
            for (int i = 0; i < NPORT; i++) begin
                if (dir_sel[i]) begin
                    dir_ff[i] <= merge(dir_ff[i], cpu);
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NPORT; i++) begin
                pullup_ff[i] <= (i == P4_IX) ? PULLUP4_RST : PULLUP_RST;
            end
        end else begin
            for (int i = 0; i < NPORT; i++) begin
                if (pu_sel[i]) begin
                    pullup_ff[i] <= merge(pullup_ff[i], cpu);
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NPORT; i++) begin
                ttl_ff[i] <= TTL_RST;
            end
        end else begin
            for (int i = 0; i < NPORT; i++) begin
                if (ttl_sel[i]) begin
                    ttl_ff[i] <= merge(ttl_ff[i], cpu);
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NPORT; i++) begin
                odrain_ff[i] <= ODRAIN_RST;
            end
        end else begin
            for (int i = 0; i < NPORT; i++) begin
                if (od_sel[i]) begin
                    odrain_ff[i] <= merge(odrain_ff[i], cpu);
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int j = 0; j < NASEL; j++) begin
                asel_ff[j] <= ASEL_RST;
            end
        end else begin
            for (int j = 0; j < NASEL; j++) begin
                if (asel_sel[j]) begin
                    asel_ff[j] <= merge(asel_ff[j], cpu);
                end
            end
        end
    end

    // Byte-only registers: bit writes are ignored
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            group_cfg_ff <= GROUP_CFG_RST;
        end else if (cpu.wr && !cpu.bit_op
                     && cpu.addr == GROUP_CFG_ADDR) begin
            group_cfg_ff <= cpu.wdata[3:0];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            redirect_ff <= REDIRECT_RST;
        end else if (cpu.wr && !cpu.bit_op
                     && cpu.addr == REDIRECT_ADDR) begin
            redirect_ff <= cpu.wdata[3:0];
        end
    end

    // Timer redirection onto the alternate pins
    always_comb begin
        for (int i = 0; i < NPORT; i++) begin
            alt_en[i] = 8'h00;
        end
        unique case (redirect_ff[3:2])
            OUT_TO_P30: alt_en[P3_IX][0] = timer_out_signal;
            OUT_TO_P50: alt_en[P5_IX][0] = timer_out_signal;
            OUT_TO_P00: alt_en[P0_IX][0] = timer_out_signal;
            default: ;
        endcase
        unique case (redirect_ff[1:0])
            IO_TO_P01: alt_en[P0_IX][1] = timer_io_signal;
            IO_TO_P31: alt_en[P3_IX][1] = timer_io_signal;
            IO_TO_PORT4_BIT1: alt_en[P4_IX][1] = timer_io_signal;
            default: ;
        endcase
    end

    always_comb begin
        unique case (redirect_ff[1:0])
            IO_TO_P01: timer_io_in = pin_in[P0_IX][1];
            IO_TO_P31: timer_io_in = pin_in[P3_IX][1];
            IO_TO_PORT4_BIT1: timer_io_in = pin_in[P4_IX][1];
            default: timer_io_in = 1'b0;
        endcase
    end

    // Pin drivers, open drain and pull-ups
    always_comb begin
        for (int i = 0; i < NPORT; i++) begin
            for (int b = 0; b < 8; b++) begin
                pin_out[i][b] = latch_ff[i][b] | alt_en[i][b];
                pin_oe_n[i][b] = dir_ff[i][b] | analog[i][b]
                    | (odrain_ff[i][b] & pin_out[i][b]);
                pullup_on[i][b] = pullup_ff[i][b] & dir_ff[i][b]
                    & ~odrain_ff[i][b] & ~analog[i][b];
                ttl_on[i][b] = ttl_ff[i][b];
            end
        end
    end

    // Read data, one cycle after the request
    always_comb begin
        nxt_rdata = 8'h00;
        for (int i = 0; i < NPORT; i++) begin
            if (cpu.addr == LATCH_BASE + PORT_NUM[i]) begin
                nxt_rdata = rd_val[i];
            end
            if (cpu.addr == DIR_BASE + PORT_NUM[i]) begin
                nxt_rdata = dir_ff[i];
            end
            if (cpu.addr == PULLUP_BASE + PORT_NUM[i]) begin
                nxt_rdata = pullup_ff[i];
            end
            if (cpu.addr == TTL_BASE + PORT_NUM[i]) begin
                nxt_rdata = ttl_ff[i];
            end
            if (cpu.addr == ODRAIN_BASE + PORT_NUM[i]) begin
                nxt_rdata = odrain_ff[i];
            end
        end
        for (int j = 0; j < NASEL; j++) begin
            if (cpu.addr == ASEL_ADDR[j]) begin
                nxt_rdata = asel_ff[j];
            end
        end
        if (cpu.addr == GROUP_CFG_ADDR) begin
            nxt_rdata = {4'h0, group_cfg_ff};
        end
        if (cpu.addr == REDIRECT_ADDR) begin
            nxt_rdata = {4'h0, redirect_ff};
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_ff <= 8'h00;
        end else if (cpu.rd) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign cpu_rdata = rdata_ff;

endmodule : port_analog_select_redirect_io

/* File: test/pin_side_model.sv */
// Pin-side model: the level that each port pin shows to the block.
// Assumes the bench gives the level of released, unpulled pins.
`timescale 1ns/1ps

module pin_side_model
    import port_ctrl_pkg::*;
(
    input wire logic [NPORT-1:0][7:0] pin_out,
    input wire logic [NPORT-1:0][7:0] pin_oe_n,
    input wire logic [NPORT-1:0][7:0] pullup_on,
    input wire logic [NPORT-1:0][7:0] ext_level,
    output logic [NPORT-1:0][7:0] pin_in
);
    // A released pin rises on the pull-up or takes the outside level
    always_comb begin
        for (int i = 0; i < NPORT; i++) begin
            for (int b = 0; b < 8; b++) begin
                pin_in[i][b] = !pin_oe_n[i][b] ? pin_out[i][b] :
                    (pullup_on[i][b] ? 1'b1 : ext_level[i][b]);
            end
        end
    end
endmodule : pin_side_model

/* File: test/port_analog_select_redirect_io_props.sv */
// Checker of the port block, bound to its top module.
// Assumes port 2 stays push-pull and latch slot 5 stays 0 while routed.
`timescale 1ns/1ps

module port_block_props
    import port_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire cpu_req_s cpu,
    input wire logic [7:0] cpu_rdata,
    input wire logic [NPORT-1:0][7:0] pin_out,
    input wire logic [NPORT-1:0][7:0] pin_oe_n,
    input wire logic [NPORT-1:0][7:0] pullup_on,
    input wire logic [7:0] group_analog,
    input wire logic [3:0] dual_analog,
    input wire logic timer_out_signal
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence byte_wr(a);
        cpu.wr && !cpu.bit_op && cpu.addr == a;
    endsequence
    sequence bit_wr(a);
        cpu.wr && cpu.bit_op && cpu.addr == a;
    endsequence
    reset_state_a: assert property (
        $rose(nrst) |-> pin_oe_n == '1 && dual_analog == 4'hF
        && group_analog == 8'hFF) else $error("bad state after reset");
    latch_drive_a: assert property (
        byte_wr(LATCH_BASE + 20'h2) |=> pin_out[P2_IX] == $past(cpu.wdata))
        else $error("latch write not on pins");
    group_digital_a: assert property (
        byte_wr(GROUP_CFG_ADDR) ##0 cpu.wdata[3:0] == GROUP_ALL_DIGITAL
        |=> group_analog == 8'h00) else $error("group not all digital");
    group_bit_a: assert property (
        bit_wr(GROUP_CFG_ADDR) |=> $stable(group_analog))
        else $error("bit write changed group config");
    upper_zero_a: assert property (
        cpu.rd && (cpu.addr == GROUP_CFG_ADDR || cpu.addr == REDIRECT_ADDR)
        |=> cpu_rdata[7:4] == 4'h0) else $error("upper nibble not zero");
    select_bit_a: assert property (
        bit_wr(ASEL_ADDR[0]) ##0 cpu.bit_idx == 3'h0
        |=> dual_analog[0] == $past(cpu.bit_val))
        else $error("analog select bit write lost");
    pullup_off_a: assert property (
        (pullup_on & ~pin_oe_n) == '0) else $error("pull-up on driven pin");
    route_out_a: assert property (
        byte_wr(REDIRECT_ADDR) ##0 cpu.wdata[3:2] == OUT_TO_P50
        |=> pin_out[P5_IX][0] == timer_out_signal)
        else $error("timer output not routed");
endmodule : port_block_props

bind port_analog_select_redirect_io port_block_props port_block_props_inst (
    .clk(clk), .nrst(nrst), .cpu(cpu), .cpu_rdata(cpu_rdata),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_on(pullup_on),
    .group_analog(group_analog), .dual_analog(dual_analog),
    .timer_out_signal(timer_out_signal));

/* File: test/port_analog_select_redirect_io_tb.sv */
// Bench of the port block: register calls with expected values.
// Assumes the pin-side model drives the pin levels.
`timescale 1ns/1ps

module port_analog_select_redirect_io_tb;
    import port_ctrl_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    cpu_req_s cpu = '0;
    logic [7:0] cpu_rdata;
    logic [NPORT-1:0][7:0] pin_in, pin_out, pin_oe_n, pullup_on, ttl_on;
    logic [NPORT-1:0][7:0] ext_level = '0;
    logic [7:0] group_analog;
    logic [3:0] dual_analog;
    logic tmr_out = 1'b0;
    logic tmr_io = 1'b0;
    logic timer_io_in;
    int fails = 0;
    int checks_done = 0;

    always #20 clk = ~clk;

    port_analog_select_redirect_io port_analog_select_redirect_io_inst (
        .clk(clk), .nrst(nrst), .cpu(cpu), .cpu_rdata(cpu_rdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pullup_on(pullup_on), .ttl_on(ttl_on),
        .group_analog(group_analog), .dual_analog(dual_analog),
        .timer_out_signal(tmr_out), .timer_io_signal(tmr_io),
        .timer_io_in(timer_io_in));
    pin_side_model pin_side_model_inst (
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_on(pullup_on),
        .ext_level(ext_level), .pin_in(pin_in));

    task automatic chk(input string what, input logic [7:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic put(input cpu_req_s q);
        @(negedge clk);
        cpu = q;
        @(negedge clk);
        cpu = '0;
    endtask : put
    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        put('{1'b0, 1'b1, 1'b0, 3'h0, 1'b0, a, d});
    endtask : wr
    task automatic bw(input logic [19:0] a, input logic [2:0] i, logic v);
        put('{1'b0, 1'b1, 1'b1, i, v, a, 8'h00});
    endtask : bw
    task automatic rd(input logic [19:0] a, logic [7:0] e, string what);
        put('{1'b1, 1'b0, 1'b0, 3'h0, 1'b0, a, 8'h00});
        chk(what, cpu_rdata, e);
    endtask : rd
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        #40000;
        fails++;
        finish_test();
    end

    initial begin
        logic [7:0] e;
        repeat (20) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        rd(ASEL_ADDR[0], 8'hFF, "analog select");
        rd(GROUP_CFG_ADDR, 8'h00, "group config");
        rd(REDIRECT_ADDR, 8'h00, "redirect");
        rd(DIR_BASE + 20'h2, 8'hFF, "direction");
        rd(LATCH_BASE + 20'h2, 8'h00, "analog port");
        rd(20'hF0070, 8'h00, "unmapped");
        for (int k = 0; k <= 8; k++) begin
            wr(GROUP_CFG_ADDR, 8'(k));
            e = k == 0 ? 8'hFF : 8'((9'h1 << (k - 1)) - 9'h1);
            chk("group pins", group_analog, e);
        end
        wr(GROUP_CFG_ADDR, 8'h03);
        chk("ref channels", group_analog, 8'h03);
        wr(GROUP_CFG_ADDR, 8'hF1);
        bw(GROUP_CFG_ADDR, 3'h3, 1'b1);
        rd(GROUP_CFG_ADDR, 8'h01, "group config");
        ext_level[P2_IX] = 8'hAA;
        wr(LATCH_BASE + 20'h2, 8'h55);
        chk("port2 enable", pin_oe_n[P2_IX], 8'hFF);
        rd(LATCH_BASE + 20'h2, 8'hAA, "port2 pins");
        wr(DIR_BASE + 20'h2, 8'h00);
        chk("port2 drive", pin_out[P2_IX], 8'h55);
        chk("port2 driven", pin_oe_n[P2_IX], 8'h00);
        rd(LATCH_BASE + 20'h2, 8'h55, "port2 latch");
        bw(LATCH_BASE + 20'h2, 3'h1, 1'b1);
        rd(LATCH_BASE + 20'h2, 8'h57, "port2 rmw out");
        wr(DIR_BASE + 20'h2, 8'hFF);
        ext_level[P2_IX] = 8'hF0;
        repeat (3) @(negedge clk);
        bw(LATCH_BASE + 20'h2, 3'h0, 1'b0);
        chk("port2 held", pin_in[P2_IX], 8'hF0);
        wr(DIR_BASE + 20'h2, 8'h00);
        chk("port2 rmw in", pin_out[P2_IX], 8'hF0);
        bw(ASEL_ADDR[0], 3'h0, 1'b0);
        chk("dual analog", {4'h0, dual_analog}, 8'h0E);
        rd(ASEL_ADDR[0], 8'hFE, "select bit");
        wr(ASEL_ADDR[1], 8'hFE);
        chk("dual analog", {4'h0, dual_analog}, 8'h0A);
        wr(ASEL_ADDR[1], 8'hFF);
        wr(ASEL_ADDR[0], 8'hFD);
        tmr_out = 1'b1;
        for (int c = 0; c < 4; c++) begin
            wr(REDIRECT_ADDR, 8'(c << 2));
            e = {5'h0, pin_out[P0_IX][0], pin_out[P5_IX][0],
                pin_out[P3_IX][0]};
            chk("timer out", e, 8'(c < 3 ? 1 << c : 0));
        end
        tmr_out = 1'b0;
        tmr_io = 1'b1;
        for (int c = 0; c < 4; c++) begin
            ext_level[P0_IX][1] = c == 0 || c == 3;
            ext_level[P3_IX][1] = c == 1 || c == 3;
            ext_level[P4_IX][1] = c == 2 || c == 3;
            wr(REDIRECT_ADDR, 8'(c) | 8'hF0);
            rd(REDIRECT_ADDR, 8'(c), "redirect");
            chk("timer io", {7'h0, timer_io_in}, {7'h0, c < 3});
            e = {5'h0, pin_out[P4_IX][1], pin_out[P3_IX][1],
                pin_out[P0_IX][1]};
            chk("timer io out", e, 8'(c < 3 ? 1 << c : 0));
        end
        tmr_io = 1'b0;
        wr(REDIRECT_ADDR, 8'h00);
        ext_level[P5_IX] = 8'h01;
        wr(PULLUP_BASE + 20'h5, 8'h01);
        wr(LATCH_BASE + 20'h5, 8'h01);
        wr(ODRAIN_BASE + 20'h5, 8'h01);
        wr(TTL_BASE + 20'h5, 8'h01);
        chk("pullup", pullup_on[P5_IX], 8'h00);
        chk("ttl", ttl_on[P5_IX], 8'h01);
        wr(DIR_BASE + 20'h5, 8'hFE);
        chk("open drain high", pin_oe_n[P5_IX], 8'hFF);
        wr(LATCH_BASE + 20'h5, 8'h00);
        chk("open drain low", pin_oe_n[P5_IX], 8'hFE);
        finish_test();
    end
endmodule : port_analog_select_redirect_io_tb
